//--- inc/vcc_consts.vh
// register map, field positions and reset values of the comparator control
`ifndef VCC_CONSTS_VH
`define VCC_CONSTS_VH
`define VCC_ADDR_CTRL 8'hF8
`define VCC_ADDR_MODE 8'h9D
`define VCC_RST_CTRL 8'h00
`define VCC_RST_MODE 2'h2
`define VCC_BIT_EN 7
`define VCC_BIT_OUT 6
`define VCC_BIT_RISE 5
`define VCC_BIT_FALL 4
`define VCC_HYP_HI 3
`define VCC_HYP_LO 2
`define VCC_HYN_HI 1
`define VCC_HYN_LO 0
`define VCC_MD_HI 1
`define VCC_MD_LO 0
`define VCC_RD_UNMAPPED 8'h00
`endif

//--- design/vcc_sync2.v
// two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module vcc_sync2 (
    input wire mclk,
    input wire rstn,
    input wire din,
    output wire dout
);
    reg s1_q;
    reg s2_q;

    // first stage is read only by the second
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
        end
    end

    assign dout = s2_q;
endmodule // vcc_sync2

//--- design/vcc_comparator_control.v
// comparator control: enable, hysteresis, mode, edge flags, pin outputs
//
// Behaviour
// - result is pollable, raises interrupts, and can drive a pin.
// - pin output offered clock-synchronous or raw asynchronous, raw needs no clock.
// - while disabled, the raw pin output is held low at once, the synchronous one from the next clock on.
// - writable response mode selects speed; slower settings save power.
// - hysteresis lives in control register bits 3 to 0.
// - positive hysteresis code sits in bits 3 to 2.
// - interrupts arise on both rising and falling output edges.
// - falling edge sets the falling flag, bit 4.
// - rising edge sets the rising flag, bit 5.
// - flags stay set until software clears them.
// - bit 6 reads back the present comparator output, read only.
// - bit 7 enables the comparator when one.
// - mode field bits 1 to 0 at 0x9D, reset 10b, 0 fastest.
`timescale 1ns/1ps
`include "vcc_consts.vh"
module vcc_comparator_control #(
    parameter ADDR_W = 8,
    parameter DATA_W = 8
) (
    input wire mclk,
    input wire rstn,
    input wire [ADDR_W-1:0] addr,
    input wire [DATA_W-1:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [DATA_W-1:0] rdata,
    input wire cmp_raw,
    output reg comparator_enable,
    output reg [1:0] pos_hyst_code,
    output reg [1:0] neg_hyst_code,
    output reg [1:0] response_mode_field,
    output reg rising_edge_flag,
    output reg falling_edge_flag,
    output reg cmp_irq,
    output reg synchronous_comparator_out,
    output wire asynchronous_comparator_out
);
    wire cmp_sync;
    reg cmp_prev_q;
    wire wr_ctrl;
    wire wr_mode;
    wire rise_ev;
    wire fall_ev;
    reg [DATA_W-1:0] rd_d;

    // raw comparator crosses into mclk before any logic but the raw pin gate looks at it
    vcc_sync2 u_sync (
        .mclk(mclk),
        .rstn(rstn),
        .din(cmp_raw),
        .dout(cmp_sync)
    );

    assign wr_ctrl = wr_en && (addr == `VCC_ADDR_CTRL);
    assign wr_mode = wr_en && (addr == `VCC_ADDR_MODE);

    // edges only counted while enabled, so a disabled core raises none
    assign rise_ev = comparator_enable && cmp_sync && !cmp_prev_q;
    assign fall_ev = comparator_enable && !cmp_sync && cmp_prev_q;

    // previous synchronised sample for edge compare
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cmp_prev_q <= 1'b0;
        end else begin
            cmp_prev_q <= cmp_sync;
        end
    end

    // control register fields, reset to all zeros
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            comparator_enable <= 1'b0;
            pos_hyst_code <= 2'h0;
            neg_hyst_code <= 2'h0;
        end else if (wr_ctrl) begin
            comparator_enable <= wdata[`VCC_BIT_EN];
            pos_hyst_code <= wdata[`VCC_HYP_HI:`VCC_HYP_LO];
            neg_hyst_code <= wdata[`VCC_HYN_HI:`VCC_HYN_LO];
        end
    end

    // response mode; analog core decodes speed against power
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            response_mode_field <= `VCC_RST_MODE;
        end else if (wr_mode) begin
            response_mode_field <= wdata[`VCC_MD_HI:`VCC_MD_LO];
        end
    end

    // sticky flags: set beats a clearing write in the same cycle
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rising_edge_flag <= 1'b0;
            falling_edge_flag <= 1'b0;
        end else begin
            if (rise_ev) begin
                rising_edge_flag <= 1'b1;
            end else if (wr_ctrl && !wdata[`VCC_BIT_RISE]) begin
                rising_edge_flag <= 1'b0;
            end
            if (fall_ev) begin
                falling_edge_flag <= 1'b1;
            end else if (wr_ctrl && !wdata[`VCC_BIT_FALL]) begin
                falling_edge_flag <= 1'b0;
            end
        end
    end

    // interrupt request follows either flag, held until software clears
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cmp_irq <= 1'b0;
        end else begin
            cmp_irq <= rising_edge_flag || falling_edge_flag;
        end
    end

    // latched pin output forced low from the first clock after disable
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            synchronous_comparator_out <= 1'b0;
        end else begin
            synchronous_comparator_out <= comparator_enable && cmp_sync;
        end
    end

    // raw output must run with no clock, so it is a gate, not a flop
    assign asynchronous_comparator_out = comparator_enable && cmp_raw;

    // read mux
    always @* begin
        rd_d = `VCC_RD_UNMAPPED;
        if (addr == `VCC_ADDR_CTRL) begin
            rd_d[`VCC_BIT_EN] = comparator_enable;
            rd_d[`VCC_BIT_OUT] = comparator_enable && cmp_sync;
            rd_d[`VCC_BIT_RISE] = rising_edge_flag;
            rd_d[`VCC_BIT_FALL] = falling_edge_flag;
            rd_d[`VCC_HYP_HI:`VCC_HYP_LO] = pos_hyst_code;
            rd_d[`VCC_HYN_HI:`VCC_HYN_LO] = neg_hyst_code;
        end else if (addr == `VCC_ADDR_MODE) begin
            rd_d[`VCC_MD_HI:`VCC_MD_LO] = response_mode_field;
        end
    end

    // read data valid the cycle after the strobe; polling path
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata <= `VCC_RD_UNMAPPED;
        end else if (rd_en) begin
            rdata <= rd_d;
        end else begin
            rdata <= `VCC_RD_UNMAPPED;
        end
    end
endmodule // vcc_comparator_control

//--- test/vcc_ctrl_monitor.sv
// concurrent checks on the comparator control ports
`timescale 1ns/1ps
module vcc_ctrl_monitor (
    input logic mclk,
    input logic rstn,
    input logic [7:0] addr,
    input logic [7:0] wdata,
    input logic wr_en,
    input logic cmp_raw,
    input logic comparator_enable,
    input logic [1:0] response_mode_field,
    input logic rising_edge_flag,
    input logic falling_edge_flag,
    input logic cmp_irq,
    input logic synchronous_comparator_out,
    input logic asynchronous_comparator_out
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // decoded write strobes per register
    wire wc = wr_en && addr == 8'hF8;
    wire wm = wr_en && addr == 8'h9D;
    wire so = synchronous_comparator_out;
    property p_raw;
        asynchronous_comparator_out == (comparator_enable & cmp_raw);
    endproperty
    a_raw: assert property (p_raw) else $error("raw pin wrong");
    property p_off; !comparator_enable [*2] |-> !so; endproperty
    a_off: assert property (p_off) else $error("pin not low");
    property p_en; wc |=> comparator_enable == $past(wdata[7]); endproperty
    a_en: assert property (p_en) else $error("enable bit");
    property p_md; wm |=> response_mode_field == $past(wdata[1:0]); endproperty
    a_md: assert property (p_md) else $error("mode field");
    // flag may only drop through a write of zero to it
    property p_hold; rising_edge_flag && !(wc && !wdata[5]) |=> rising_edge_flag;
    endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
    property p_irq; cmp_irq == $past(rising_edge_flag | falling_edge_flag);
    endproperty
    a_irq: assert property (p_irq) else $error("irq wrong");
    // enable must predate the rise, else turning on over a high input
    // lifts the pin with no edge behind it
    property p_rise;
        $rose(so) && $past(comparator_enable, 2) |-> ##[0:1] rising_edge_flag;
    endproperty
    a_rise: assert property (p_rise) else $error("rise flag");
    // the drop must come from the input while enabled, not from turning off
    property p_fall;
        $fell(so) && $past(comparator_enable) |-> ##[0:1] falling_edge_flag;
    endproperty
    a_fall: assert property (p_fall) else $error("fall flag");
endmodule // vcc_ctrl_monitor
bind vcc_comparator_control vcc_ctrl_monitor i_vcc_ctrl_monitor (.mclk, .rstn,
    .addr, .wdata, .wr_en, .cmp_raw, .comparator_enable, .response_mode_field,
    .rising_edge_flag, .falling_edge_flag, .cmp_irq,
    .synchronous_comparator_out, .asynchronous_comparator_out);

//--- test/vcc_cmp_model.sv
// behavioural analog comparator core driving the raw result
`timescale 1ns/1ps
module vcc_cmp_model (
    input wire lvl,
    output wire cmp_raw
);
    // settles off the clock edge, like a real analog output
    assign #3 cmp_raw = lvl;
endmodule // vcc_cmp_model

//--- test/testbench.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module testbench;
    logic mclk = 0, rstn = 0, wr_en = 0, rd_en = 0, lvl = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    wire [7:0] rdata;
    wire cmp_raw, so, ao;
    int error_cnt = 0, checks_done = 0;
    vcc_cmp_model i_vcc_cmp_model (.lvl, .cmp_raw);
    vcc_comparator_control i_vcc_comparator_control (.mclk, .rstn, .addr,
        .wdata, .wr_en, .rd_en, .rdata, .cmp_raw, .comparator_enable(),
        .pos_hyst_code(), .neg_hyst_code(), .response_mode_field(),
        .rising_edge_flag(), .falling_edge_flag(), .cmp_irq(),
        .synchronous_comparator_out(so), .asynchronous_comparator_out(ao));
    initial forever #20 mclk = ~mclk;
    task chk(input logic [7:0] g, e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_en <= 1;
        @(posedge mclk);
        wr_en <= 0;
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, e);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1;
        @(posedge mclk);
        rd_en <= 0;
        #1 chk(rdata, e);
    endtask
    task end_of_test;
        if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rstn <= 1;
        rd(8'hF8, 8'h00);
        rd(8'h9D, 8'h02);
        for (int i = 0; i < 4; i++) begin
            wr(8'h9D, 8'hFC | i[7:0]);
            rd(8'h9D, i[7:0]);
        end
        wr(8'h10, 8'h55);
        rd(8'h10, 8'h00);
        wr(8'hF8, 8'hCF);
        rd(8'hF8, 8'h8F);
        lvl <= 1;
        repeat (4) @(posedge mclk);
        rd(8'hF8, 8'hEF);
        chk({6'h00, so, ao}, 8'h03);
        lvl <= 0;
        repeat (4) @(posedge mclk);
        rd(8'hF8, 8'hBF);
        wr(8'hF8, 8'h9F);
        rd(8'hF8, 8'h9F);
        wr(8'hF8, 8'h8F);
        rd(8'hF8, 8'h8F);
        // disable first so no edge is seen on the way
        wr(8'hF8, 8'h00);
        lvl <= 1;
        repeat (4) @(posedge mclk);
        chk({6'h00, so, ao}, 8'h00);
        rd(8'hF8, 8'h00);
        end_of_test;
    end
endmodule // testbench
